//--- rtl/pdm_pkg.sv
package pdm_pkg;
  // ==========================================================
  // Timing of the two-wire spike filter
  localparam int unsigned PDM_CLK_PERIOD_PS = 4000;   // 250 MHz system clock
  localparam int unsigned PDM_SPIKE_NS      = 50;     // Longest spike dropped
  // Longest time rounds down, at least one cycle
  localparam int unsigned PDM_SPIKE_CYC_RAW = (PDM_SPIKE_NS * 1000) / PDM_CLK_PERIOD_PS;
  localparam int unsigned PDM_SPIKE_CYC     = (PDM_SPIKE_CYC_RAW < 1) ? 1 : PDM_SPIKE_CYC_RAW;

  // ==========================================================
  // Pin indices
  localparam int unsigned PDM_PD_TWCLK   = 0;
  localparam int unsigned PDM_PD_TWDATA  = 1;
  localparam int unsigned PDM_PD_RX1     = 2;
  localparam int unsigned PDM_PD_TX1     = 3;
  localparam int unsigned PDM_PD_CAP1    = 4;
  localparam int unsigned PDM_PD_USART1_CLOCK_PIN    = 5;
  localparam int unsigned PDM_PD_T1      = 6;
  localparam int unsigned PDM_PD_T2      = 7;
  localparam int unsigned PDM_PE_TX0     = 1;
  localparam int unsigned PDM_PE_USART0_CLOCK_PIN    = 2;
  localparam int unsigned PDM_PE_MA      = 3;
  localparam int unsigned PDM_PE_MB      = 4;
  localparam int unsigned PDM_PE_MC      = 5;
  localparam int unsigned PDM_PE_T3      = 6;
  localparam int unsigned PDM_PE_CAP3    = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PDM_RST_BYTE    = 8'h00;
  localparam logic       PDM_RST_LINE    = 1'b1;   // Two-wire lines idle high

  // Filter state
  typedef enum logic [0:0] {
    PDM_FLT_STABLE  = 1'b0,
    PDM_FLT_PENDING = 1'b1
  } pdm_flt_state_t;
endpackage : pdm_pkg

//--- rtl/pdm_port_de_mux.sv
// How it works
// - Port D pin 4 synchronized value feeds timer 1 capture input.
// - Port D pins 3..0 feed interrupts 3..0; enabled interrupt forces input enable.
// - USART1 transmit forces pin D3 output with transmit data, pull-up off.
// - USART1 receive forces pin D2 input; pull-up follows data bit unless globally off.
// - Two-wire enable makes D1 open-drain data: value 0, direction from drive.
// - Two-wire enable makes D0 open-drain clock: value 0, direction from drive.
// - Both two-wire inputs drop pulses shorter than 50 ns while enabled.
// - Filters sit only on the two-wire path; port input path unfiltered.
// - Port E pins 7..4 feed interrupts 7..4 with forced input enable.
// - Port E pin 7 feeds timer 3 capture input.
// - Port E pin 6 feeds timer 3 count clock.
// - Port E pin 5 carries timer 3 match C when enabled; software sets direction.
// - Port E pin 4 carries timer 3 match B when enabled; software sets direction.
// - Port E pin 3 carries timer 3 match A when enabled; software sets direction.
// - Port E pin 2 is USART0 clock in sync mode; direction bit picks way.
// - Port E pin 1 drives programming data out during serial download.
// - Otherwise port E pin 1 is USART0 transmit output while USART0 transmit is enabled.
// - Legacy mode disables timer 3 pin functions and USART0 clock pin.
// - Port D pin 5 is USART1 clock in sync mode; direction bit picks way.
// - Port D pins 7 and 6 feed timer 2 and timer 1 count clocks.
`timescale 1ns/10ps
`default_nettype none
module pdm_port_de_mux
  import pdm_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = PDM_SPIKE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // General-purpose port registers
  input  wire logic [7:0] port_d_data,
  input  wire logic [7:0] port_d_dir,
  input  wire logic [7:0] port_e_data,
  input  wire logic [7:0] port_e_dir,
  input  wire logic       global_pullup_off,
  input  wire logic       legacy_mode,
  // Pad inputs
  input  wire logic [7:0] pad_d_in,
  input  wire logic [7:0] pad_e_in,
  // Peripheral controls
  input  wire logic [7:0] ext_irq_enable,
  input  wire logic       usart1_tx_enable,
  input  wire logic       usart1_rx_enable,
  input  wire logic       usart1_tx_data,
  input  wire logic       usart1_sync_select,
  input  wire logic       usart1_clk_out,
  input  wire logic       two_wire_enable,
  input  wire logic       two_wire_data_drive,
  input  wire logic       two_wire_clk_drive,
  input  wire logic       timer3_match_a_en,
  input  wire logic       timer3_match_a_out,
  input  wire logic       timer3_match_b_en,
  input  wire logic       timer3_match_b_out,
  input  wire logic       timer3_match_c_en,
  input  wire logic       timer3_match_c_out,
  input  wire logic       usart0_sync_select,
  input  wire logic       usart0_clk_out,
  input  wire logic       usart0_tx_enable,
  input  wire logic       usart0_tx_data,
  input  wire logic       serial_prog_active,
  input  wire logic       serial_prog_out,
  // Pad controls
  output logic      [7:0] pad_d_out,
  output logic      [7:0] pad_d_oe,
  output logic      [7:0] pad_d_pullup,
  output logic      [7:0] pad_e_out,
  output logic      [7:0] pad_e_oe,
  output logic      [7:0] pad_e_pullup,
  // Synchronized port read-back
  output logic      [7:0] port_d_pins,
  output logic      [7:0] port_e_pins,
  // Peripheral inputs
  output logic      [7:0] ext_irq_in,
  output logic            timer1_capture_in,
  output logic            timer3_capture_in,
  output logic            timer1_count_clk,
  output logic            timer2_count_clk,
  output logic            timer3_count_clk,
  output logic            usart1_rx_data,
  output logic            usart1_clock_pin,
  output logic            usart0_clock_pin,
  output logic            two_wire_data_in,
  output logic            two_wire_clk_in
);

  // ==========================================================
  // Override selection per control
  function automatic logic ovr(input logic en, input logic val, input logic dflt);
    ovr = en ? val : dflt;
  endfunction : ovr

  // Pull-up a plain input gets from its port bits
  function automatic logic pu_dflt(input logic data, input logic dir, input logic off);
    pu_dflt = data & ~dir & ~off;
  endfunction : pu_dflt

  // ==========================================================
  // Three-stage pad synchronizers
  logic [7:0] d_s1_r, d_s2_r, d_s3_r;
  logic [7:0] e_s1_r, e_s2_r, e_s3_r;
  logic [7:0] d_pin_r, e_pin_r;
  wire  logic [7:0] d_pin_nxt;
  wire  logic [7:0] e_pin_nxt;

  // Idle-high lines start high: no false start bit or bus edge after reset
  localparam logic [7:0] D_SYNC_RST = {5'h00, {3{PDM_RST_LINE}}};

  // Change accepted once second and third stages agree
  assign d_pin_nxt = (d_s2_r & d_s3_r) | (d_pin_r & (d_s2_r ^ d_s3_r));
  assign e_pin_nxt = (e_s2_r & e_s3_r) | (e_pin_r & (e_s2_r ^ e_s3_r));

  // Port D synchronizer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      d_s1_r  <= D_SYNC_RST;
      d_s2_r  <= D_SYNC_RST;
      d_s3_r  <= D_SYNC_RST;
      d_pin_r <= D_SYNC_RST;
    end else begin
      d_s1_r  <= pad_d_in;
      d_s2_r  <= d_s1_r;
      d_s3_r  <= d_s2_r;
      d_pin_r <= d_pin_nxt;
    end
  end

  // Port E synchronizer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      e_s1_r  <= PDM_RST_BYTE;
      e_s2_r  <= PDM_RST_BYTE;
      e_s3_r  <= PDM_RST_BYTE;
      e_pin_r <= PDM_RST_BYTE;
    end else begin
      e_s1_r  <= pad_e_in;
      e_s2_r  <= e_s1_r;
      e_s3_r  <= e_s2_r;
      e_pin_r <= e_pin_nxt;
    end
  end

  // ==========================================================
  // Override enables and values, port D
  wire logic [7:0] d_pu_oe, d_pu_ov, d_dd_oe, d_dd_ov, d_pv_oe, d_pv_ov, d_die_oe;
  wire logic       pu_ok_2, pu_ok_1, pu_ok_0;
  wire logic       t3_pins_on;
  wire logic       usart0_clock_pin_on;

  assign pu_ok_2 = port_d_data[PDM_PD_RX1] & ~global_pullup_off;
  assign pu_ok_1 = port_d_data[PDM_PD_TWDATA] & ~global_pullup_off;
  assign pu_ok_0 = port_d_data[PDM_PD_TWCLK] & ~global_pullup_off;

  // Pull-up override enables and values
  assign d_pu_oe = {4'h0, usart1_tx_enable, usart1_rx_enable,
                    two_wire_enable, two_wire_enable};
  assign d_pu_ov = {4'h0, 1'b0, pu_ok_2, pu_ok_1, pu_ok_0};
  // Direction override enables and values
  assign d_dd_oe = d_pu_oe;
  assign d_dd_ov = {4'h0, 1'b1, 1'b0,
                    two_wire_data_drive, two_wire_clk_drive};
  // Output value override enables and values
  assign d_pv_oe = {2'h0, usart1_sync_select, 1'b0, usart1_tx_enable, 1'b0,
                    two_wire_enable, two_wire_enable};
  assign d_pv_ov = {2'h0, usart1_clk_out, 1'b0, usart1_tx_data, 1'b0,
                    1'b0, 1'b0};
  // Interrupt enables force digital input on
  assign d_die_oe = {4'h0, ext_irq_enable[3:0]};

  // ==========================================================
  // Override enables and values, port E
  wire logic [7:0] e_pv_oe, e_pv_ov, e_die_oe;
  wire logic       tx0_on;

  assign t3_pins_on = ~legacy_mode;
  assign usart0_clock_pin_on    = usart0_sync_select & ~legacy_mode;
  assign tx0_on     = serial_prog_active | usart0_tx_enable;
  assign e_pv_oe = {2'h0,
                    timer3_match_c_en & t3_pins_on,
                    timer3_match_b_en & t3_pins_on,
                    timer3_match_a_en & t3_pins_on,
                    usart0_clock_pin_on, tx0_on, 1'b0};
  assign e_pv_ov = {2'h0, timer3_match_c_out, timer3_match_b_out, timer3_match_a_out,
                    usart0_clk_out,
                    serial_prog_active ? serial_prog_out : usart0_tx_data,
                    1'b0};
  assign e_die_oe = {ext_irq_enable[7:4], 4'h0};

  // ==========================================================
  // Final pad control selection
  logic [7:0] d_out_nxt, d_oe_nxt, d_pu_nxt, e_out_nxt, e_oe_nxt, e_pu_nxt;
  logic [7:0] d_die, e_die;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      d_out_nxt[i] = ovr(d_pv_oe[i], d_pv_ov[i], port_d_data[i]);
      d_oe_nxt[i]  = ovr(d_dd_oe[i], d_dd_ov[i], port_d_dir[i]);
      d_pu_nxt[i]  = ovr(d_pu_oe[i], d_pu_ov[i], pu_dflt(port_d_data[i], port_d_dir[i], global_pullup_off));
      d_die[i]     = ovr(d_die_oe[i], 1'b1, 1'b1);
      e_out_nxt[i] = ovr(e_pv_oe[i], e_pv_ov[i], port_e_data[i]);
      e_oe_nxt[i]  = port_e_dir[i];
      e_pu_nxt[i]  = pu_dflt(port_e_data[i], port_e_dir[i], global_pullup_off);
      e_die[i]     = ovr(e_die_oe[i], 1'b1, 1'b1);
    end
    // Transmit line is an output while in use
    if (tx0_on) begin
      e_oe_nxt[PDM_PE_TX0] = 1'b1;
      e_pu_nxt[PDM_PE_TX0] = 1'b0;
    end
  end

  // Input enable stays on: no sleep gating in this block
  wire logic [7:0] d_in_gated;
  wire logic [7:0] e_in_gated;
  assign d_in_gated = d_pin_r & d_die;
  assign e_in_gated = e_pin_r & e_die;

  // ==========================================================
  // Two-wire spike filters on the peripheral path only
  wire logic tw_data_flt;
  wire logic tw_clk_flt;

  pdm_spike_filter #(
    .CYCLES (FILTER_CYCLES)
  ) u_flt_data (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (two_wire_enable),
    .din    (d_pin_r[PDM_PD_TWDATA]),
    .dout   (tw_data_flt)
  );

  pdm_spike_filter #(
    .CYCLES (FILTER_CYCLES)
  ) u_flt_clk (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (two_wire_enable),
    .din    (d_pin_r[PDM_PD_TWCLK]),
    .dout   (tw_clk_flt)
  );

  // ==========================================================
  // Pad control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pad_d_out         <= PDM_RST_BYTE;
      pad_d_oe          <= PDM_RST_BYTE;
      pad_d_pullup      <= PDM_RST_BYTE;
      pad_e_out         <= PDM_RST_BYTE;
      pad_e_oe          <= PDM_RST_BYTE;
      pad_e_pullup      <= PDM_RST_BYTE;
    end else begin
      pad_d_out         <= d_out_nxt;
      pad_d_oe          <= d_oe_nxt;
      pad_d_pullup      <= d_pu_nxt;
      pad_e_out         <= e_out_nxt;
      pad_e_oe          <= e_oe_nxt;
      pad_e_pullup      <= e_pu_nxt;
    end
  end

  // Port read-back and interrupt inputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_d_pins       <= PDM_RST_BYTE;
      port_e_pins       <= PDM_RST_BYTE;
      ext_irq_in        <= PDM_RST_BYTE;
    end else begin
      port_d_pins       <= d_pin_r;
      port_e_pins       <= e_pin_r;
      ext_irq_in        <= {e_in_gated[7:4], d_in_gated[3:0]};
    end
  end

  // Timer capture and count inputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer1_capture_in <= 1'b0;
      timer3_capture_in <= 1'b0;
      timer1_count_clk  <= 1'b0;
      timer2_count_clk  <= 1'b0;
      timer3_count_clk  <= 1'b0;
    end else begin
      timer1_capture_in <= d_in_gated[PDM_PD_CAP1];
      timer3_capture_in <= e_in_gated[PDM_PE_CAP3] & t3_pins_on;
      timer1_count_clk  <= d_in_gated[PDM_PD_T1];
      timer2_count_clk  <= d_in_gated[PDM_PD_T2];
      timer3_count_clk  <= e_in_gated[PDM_PE_T3] & t3_pins_on;
    end
  end

  // Serial and two-wire inputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      usart1_rx_data    <= 1'b1;
      usart1_clock_pin  <= 1'b0;
      usart0_clock_pin  <= 1'b0;
      two_wire_data_in  <= PDM_RST_LINE;
      two_wire_clk_in   <= PDM_RST_LINE;
    end else begin
      usart1_rx_data    <= d_in_gated[PDM_PD_RX1];
      usart1_clock_pin  <= d_in_gated[PDM_PD_USART1_CLOCK_PIN] & usart1_sync_select;
      usart0_clock_pin  <= e_in_gated[PDM_PE_USART0_CLOCK_PIN] & usart0_clock_pin_on;
      two_wire_data_in  <= tw_data_flt;
      two_wire_clk_in   <= tw_clk_flt;
    end
  end
endmodule : pdm_port_de_mux
`default_nettype wire

//--- rtl/pdm_spike_filter.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_spike_filter
  import pdm_pkg::*;
#(
  parameter int unsigned CYCLES = PDM_SPIKE_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic din,
  output var  logic dout
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  pdm_flt_state_t  state_r;
  pdm_flt_state_t  state_nxt;
  logic [CW-1:0]   cnt_r;
  logic [CW-1:0]   cnt_nxt;
  logic            out_nxt;
  wire logic       differs;
  wire logic       done;

  // Change detection and hold-time reached
  assign differs = (din != dout);
  assign done    = (cnt_r >= CW'(CYCLES));

  // ==========================================================
  // Next state: a level must hold for CYCLES+1 cycles before passing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = dout;
    case (state_r)
      PDM_FLT_STABLE: begin
        cnt_nxt = CW'(1);
        if (differs && enable) begin
          state_nxt = PDM_FLT_PENDING;
        end else if (differs) begin
          out_nxt = din;                  // Filter bypassed while disabled
        end
      end
      PDM_FLT_PENDING: begin
        if (!differs) begin
          state_nxt = PDM_FLT_STABLE;     // Short spike dropped
        end else if (done) begin
          out_nxt   = din;
          state_nxt = PDM_FLT_STABLE;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        state_nxt = PDM_FLT_STABLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= PDM_FLT_STABLE;
      cnt_r   <= '0;
      dout    <= PDM_RST_LINE;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      dout    <= out_nxt;
    end
  end
endmodule : pdm_spike_filter
`default_nettype wire

//--- verification/pdm_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_pad_model (
  input  wire logic       mclk,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  // ==========================================================
  // Pad wire resolution
  logic [7:0] float_r = 8'h55;
  // Undriven pads without pull-up wander every cycle
  always_ff @(posedge mclk) float_r <= ~float_r;
  // Device drive wins, then the outside party, then pull-up
  assign pad_in = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | float_r));
endmodule : pdm_pad_model
`default_nettype wire

//--- verification/pdm_port_de_mux_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_port_de_mux_sva (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] port_d_data,
  input wire logic [7:0] port_d_dir,
  input wire logic [7:0] port_e_data,
  input wire logic [7:0] port_e_dir,
  input wire logic       global_pullup_off,
  input wire logic       legacy_mode,
  input wire logic       usart1_tx_enable,
  input wire logic       usart1_rx_enable,
  input wire logic       usart1_tx_data,
  input wire logic       two_wire_enable,
  input wire logic       two_wire_data_drive,
  input wire logic       two_wire_clk_drive,
  input wire logic       timer3_match_c_en,
  input wire logic       timer3_match_c_out,
  input wire logic       usart0_tx_enable,
  input wire logic       usart0_tx_data,
  input wire logic       serial_prog_active,
  input wire logic       serial_prog_out,
  input wire logic [7:0] pad_d_out,
  input wire logic [7:0] pad_d_oe,
  input wire logic [7:0] pad_d_pullup,
  input wire logic [7:0] pad_e_out,
  input wire logic [7:0] pad_e_oe,
  input wire logic [7:0] port_d_pins,
  input wire logic [7:0] port_e_pins,
  input wire logic [7:0] ext_irq_in,
  input wire logic       timer1_capture_in
);
  // ==========================================================
  // Pad control and input path properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_tx1_drive: assert property (usart1_tx_enable |=> pad_d_oe[3] && !pad_d_pullup[3]
    && pad_d_out[3] == $past(usart1_tx_data)) else $error("tx1 pin wrong");
  a_rx1_input: assert property (usart1_rx_enable |=> !pad_d_oe[2]
    && pad_d_pullup[2] == $past(port_d_data[2] && !global_pullup_off)) else $error("rx1 pin wrong");
  a_tw_data: assert property (two_wire_enable |=> !pad_d_out[1]
    && pad_d_oe[1] == $past(two_wire_data_drive)) else $error("tw data pin wrong");
  a_tw_clk: assert property (two_wire_enable |=> !pad_d_out[0]
    && pad_d_oe[0] == $past(two_wire_clk_drive)) else $error("tw clock pin wrong");
  a_match_c: assert property (timer3_match_c_en && !legacy_mode |=>
    pad_e_out[5] == $past(timer3_match_c_out) && pad_e_oe[5] == $past(port_e_dir[5])) else $error("match c wrong");
  a_legacy_gate: assert property (legacy_mode |=> pad_e_out[5:2] == $past(port_e_data[5:2]))
    else $error("legacy gate wrong");
  a_prog_out: assert property (serial_prog_active |=> pad_e_oe[1]
    && pad_e_out[1] == $past(serial_prog_out)) else $error("prog out wrong");
  a_tx0_out: assert property (usart0_tx_enable && !serial_prog_active |=> pad_e_oe[1]
    && pad_e_out[1] == $past(usart0_tx_data)) else $error("tx0 pin wrong");
  a_port_dflt: assert property (!usart1_tx_enable && !usart1_rx_enable |=>
    pad_d_oe[3:2] == $past(port_d_dir[3:2])) else $error("port default wrong");
  a_irq_follow: assert property ($past(rst_n) |->
    ext_irq_in == {port_e_pins[7:4], port_d_pins[3:0]}) else $error("irq input wrong");
  a_cap1_follow: assert property ($past(rst_n) |-> timer1_capture_in == port_d_pins[4])
    else $error("capture 1 wrong");
endmodule : pdm_port_de_mux_sva
`default_nettype wire

//--- verification/pdm_port_de_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_port_de_mux_tb;
  import pdm_pkg::*;
  // ==========================================================
  // Signals
  logic       mclk, rst_n, global_pullup_off, legacy_mode, usart1_tx_enable, usart1_rx_enable;
  logic       usart1_tx_data, usart1_sync_select, usart1_clk_out, two_wire_enable, two_wire_data_drive;
  logic       two_wire_clk_drive, timer3_match_a_en, timer3_match_a_out, timer3_match_b_en;
  logic       timer3_match_b_out, timer3_match_c_en, timer3_match_c_out, usart0_sync_select;
  logic       usart0_clk_out, usart0_tx_enable, usart0_tx_data, serial_prog_active, serial_prog_out;
  logic [7:0] port_d_data, port_d_dir, port_e_data, port_e_dir, ext_irq_enable, pad_d_in, pad_e_in;
  logic [7:0] pad_d_out, pad_d_oe, pad_d_pullup, pad_e_out, pad_e_oe, pad_e_pullup;
  logic [7:0] port_d_pins, port_e_pins, ext_irq_in, d_ext_en, d_ext_val, e_ext_en, e_ext_val;
  logic       timer1_capture_in, timer3_capture_in, timer1_count_clk, timer2_count_clk;
  logic       timer3_count_clk, usart1_rx_data, usart1_clock_pin, usart0_clock_pin;
  logic       two_wire_data_in, two_wire_clk_in, mn_pin, mn_tw;
  logic [7:0] pat [2] = '{8'hB5, 8'h4A};
  int         fails = 0, comparisons = 0, cycles = 0;

  // Design, with a short filter, and both pad models
  pdm_port_de_mux #(.FILTER_CYCLES(6)) pdm_port_de_mux_inst (.*);
  pdm_pad_model pdm_pad_model_d_inst (.mclk(mclk), .oe(pad_d_oe), .out(pad_d_out), .pu(pad_d_pullup),
    .ext_en(d_ext_en), .ext_val(d_ext_val), .pad_in(pad_d_in));
  pdm_pad_model pdm_pad_model_e_inst (.mclk(mclk), .oe(pad_e_oe), .out(pad_e_out), .pu(pad_e_pullup),
    .ext_en(e_ext_en), .ext_val(e_ext_val), .pad_in(pad_e_in));

  // Clock and hang guard
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      final_report();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Track lowest level of raw and filtered data line
  task automatic watch(input int n);
    repeat (n) begin
      cyc(1);
      mn_pin = mn_pin & port_d_pins[1];
      mn_tw = mn_tw & two_wire_data_in;
    end
  endtask : watch

  task automatic pulse(input int len);
    mn_pin = 1'b1;
    mn_tw = 1'b1;
    d_ext_val[1] = 1'b0;
    watch(len);
    d_ext_val[1] = 1'b1;
    watch(30);
  endtask : pulse

  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    {global_pullup_off, legacy_mode, usart1_tx_enable, usart1_rx_enable, usart1_tx_data, usart1_sync_select,
     usart1_clk_out, two_wire_enable, two_wire_data_drive, two_wire_clk_drive, timer3_match_a_en,
     timer3_match_a_out, timer3_match_b_en, timer3_match_b_out, timer3_match_c_en, timer3_match_c_out,
     usart0_sync_select, usart0_clk_out, usart0_tx_enable, usart0_tx_data, serial_prog_active,
     serial_prog_out, rst_n} = '0;
    {port_d_data, port_d_dir, port_e_data, port_e_dir, ext_irq_enable} = '0;
    {d_ext_en, d_ext_val, e_ext_en, e_ext_val} = '1;
    cyc(5);
    chk({6'h0, usart1_rx_data, two_wire_data_in}, 8'h03);
    chk(pad_d_oe | pad_e_oe, 8'h00);
    rst_n = 1'b1;
    port_d_dir = 8'hA5;
    port_d_data = 8'h3C;
    cyc(2);
    chk(pad_d_oe, 8'hA5);
    chk(pad_d_out, 8'h3C);
    chk(pad_d_pullup, 8'h18);
    $display("test port_default done");
    {usart1_tx_enable, usart1_tx_data, usart1_rx_enable, usart1_sync_select, usart1_clk_out} = '1;
    port_d_dir = 8'h24;
    port_d_data = 8'h04;
    cyc(2);
    chk(pad_d_oe, 8'h28);
    chk(pad_d_out, 8'h2C);
    chk(pad_d_pullup, 8'h04);
    global_pullup_off = 1'b1;
    cyc(2);
    chk(pad_d_pullup, 8'h00);
    $display("test usart1 done");
    {usart1_tx_enable, usart1_rx_enable, global_pullup_off} = '0;
    port_d_dir = 8'h03;
    port_d_data = 8'h03;
    two_wire_enable = 1'b1;
    two_wire_data_drive = 1'b1;
    cyc(2);
    chk({4'h0, pad_d_oe[1:0], pad_d_out[1:0]}, 8'h08);
    {two_wire_data_drive, two_wire_clk_drive} = 2'b01;
    cyc(2);
    chk({4'h0, pad_d_oe[1:0], pad_d_out[1:0]}, 8'h04);
    two_wire_clk_drive = 1'b0;
    port_d_dir = 8'h00;
    cyc(20);
    pulse(3);
    chk({6'h0, mn_pin, mn_tw}, 8'h01);
    pulse(20);
    chk({7'h0, mn_tw}, 8'h00);
    two_wire_enable = 1'b0;
    cyc(5);
    pulse(3);
    chk({7'h0, mn_tw}, 8'h00);
    $display("test two_wire done");
    {timer3_match_a_en, timer3_match_a_out, timer3_match_b_en, timer3_match_c_en, timer3_match_c_out} = '1;
    {usart0_sync_select, usart0_clk_out} = '1;
    port_e_dir = 8'h3C;
    cyc(2);
    chk(pad_e_out & 8'h3C, 8'h2C);
    chk(pad_e_oe & 8'h3C, 8'h3C);
    legacy_mode = 1'b1;
    port_e_data = 8'h10;
    cyc(2);
    chk(pad_e_out & 8'h3C, 8'h10);
    legacy_mode = 1'b0;
    {timer3_match_a_en, timer3_match_b_en, timer3_match_c_en} = '0;
    port_e_dir = 8'h00;
    port_e_data = 8'h02;
    usart0_tx_enable = 1'b1;
    cyc(2);
    chk({5'h0, pad_e_oe[1], pad_e_out[1], pad_e_pullup[1]}, 8'h04);
    {serial_prog_active, serial_prog_out} = '1;
    cyc(2);
    chk({5'h0, pad_e_oe[1], pad_e_out[1], pad_e_pullup[1]}, 8'h06);
    {serial_prog_active, usart0_tx_enable} = '0;
    $display("test port_e done");
    {usart1_rx_enable, usart1_sync_select} = '1;
    ext_irq_enable = 8'hFF;
    foreach (pat[i]) begin
      d_ext_val = pat[i];
      e_ext_val = ~pat[i];
      cyc(10);
      chk(ext_irq_in, {e_ext_val[7:4], d_ext_val[3:0]});
      chk({timer2_count_clk, timer1_count_clk, usart1_clock_pin, timer1_capture_in, timer3_capture_in,
           timer3_count_clk, usart0_clock_pin, usart1_rx_data},
          {d_ext_val[7:4], e_ext_val[7:6], e_ext_val[2], d_ext_val[2]});
      chk(port_d_pins, d_ext_val);
      chk(port_e_pins, e_ext_val);
      chk({7'h0, two_wire_clk_in}, {7'h0, d_ext_val[0]});
    end
    chk(pad_e_pullup, 8'h02);
    legacy_mode = 1'b1;
    cyc(2);
    chk({5'h00, timer3_capture_in, timer3_count_clk, usart0_clock_pin}, 8'h00);
    $display("test inputs done");
    final_report();
  end
endmodule : pdm_port_de_mux_tb

bind pdm_port_de_mux pdm_port_de_mux_sva pdm_port_de_mux_sva_inst (.*);
`default_nettype wire
